// File: hdl/sls_supervisor.sv
`timescale 1ns/1ns
// How it works
// [RL1] Mode 0 disables the channel; condition and events stay low; reset mode.
// [RL2] Mode 1: condition while filtered value is below the lower limit.
// [RL3] Mode 2: condition while filtered value is above the upper limit.
// [RL4] Mode 3: condition while value magnitude is below lower limit magnitude.
// [RL5] Mode 4: condition while value magnitude exceeds upper limit magnitude.
// [RL6] Mode 5: condition while value is below low or above high.
// [RL7] Mode 6: magnitude below low magnitude or above high magnitude.
// [RL8] Mode 7: set above limit plus half hysteresis, clear below limit minus half.
// [RL9] Hysteresis band centres on the upper limit; inside it the condition holds.
// [RL10] Action 0, the reset value, raises no warning and no fault.
// [RL11] Action 1 raises a warning with code A8B1 while the condition holds.
// [RL12] Action 2 trips a fault with code 80B1 when the condition rises.
// [RL13] Action 3 trips fault code 80B0 only if the drive is running.
// [RL14] The status condition bit follows the comparison only, never the action.
// [RL15] A source selector picks the monitored signal; reset choice is current.
// [RL16] First-order filter, 0 to 30000 ms in 1 ms steps; zero means none.
// [RL17] Lower limit is signed hundredths within +-21474836.00, reset zero.
// [RL18] Upper limit is signed hundredths within the same range, reset zero.
// [RL19] Hysteresis is hundredths from zero to 100000.00, reset zero.
// [RL20] Separate mode and action settings steer comparison and events.
// [RL21] Each sample tick that finds the filter idle updates the filter, then compares and updates outputs.
module sls_supervisor
	import sls_pkg::*;
#(
	parameter int NUM_SRC = 28
)
(
	// Clock and reset
	input  wire logic                     clock_in,
	input  wire logic                     sys_rst_in,
	// Register port
	input  wire logic [sls_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]              reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic      [31:0]              reg_rdata_out,
	// Monitored signals
	input  wire logic [NUM_SRC-1:0][31:0] src_in,
	input  wire logic                     sample_tick_in,
	input  wire logic                     drive_running_in,
	// Events to the warning and fault handling
	output sls_pkg::sls_event_s           event_out
);
	import sls_pkg::*;

	// ==========================================================
	// Parameter check
	// ==========================================================
	if (NUM_SRC < 1 || NUM_SRC > 32)
	begin : g_bad_num_src
		$error("NUM_SRC must lie between 1 and 32.");
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic [33:0] sx34(input logic [31:0] v);
		sx34 = {{2{v[31]}}, v};
	endfunction : sx34

	function automatic logic [33:0] mag34(input logic [31:0] v);
		mag34 = v[31] ? (34'h000000000 - sx34(v)) : sx34(v);
	endfunction : mag34

	function automatic logic [31:0] clamp_limit(input logic [31:0] v);
		if ($signed(v) > $signed(LIMIT_MAX))
			clamp_limit = LIMIT_MAX;
		else if ($signed(v) < $signed(LIMIT_MIN))
			clamp_limit = LIMIT_MIN;
		else
			clamp_limit = v;
	endfunction : clamp_limit

	// ==========================================================
	// Configuration registers
	// ==========================================================
	sls_cfg_s cfg_q;

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			cfg_q.mode   <= sls_mode_e'(RST_MODE); // [RL1]
			cfg_q.action <= sls_action_e'(RST_ACTION); // [RL10]
			cfg_q.source <= RST_SOURCE; // [RL15]
			cfg_q.ftime  <= RST_FTIME; // [RL16]
			cfg_q.low    <= RST_LIMIT; // [RL17]
			cfg_q.high   <= RST_LIMIT; // [RL18]
			cfg_q.hyst   <= RST_HYST; // [RL19]
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				OFS_CTRL:
				begin
					cfg_q.mode   <= sls_mode_e'(reg_wdata_in[POS_MODE +: 3]); // [RL20]
					cfg_q.action <= sls_action_e'(reg_wdata_in[POS_ACTION +: 2]); // [RL20]
					cfg_q.source <= reg_wdata_in[POS_SOURCE +: 5]; // [RL15]
				end
				OFS_FTIME:
				begin
					if (reg_wdata_in > {17'h00000, FTIME_MAX_MS})
						cfg_q.ftime <= FTIME_MAX_MS; // [RL16]
					else
						cfg_q.ftime <= reg_wdata_in[14:0];
				end
				OFS_LOW:
					cfg_q.low <= clamp_limit(reg_wdata_in); // [RL17]
				OFS_HIGH:
					cfg_q.high <= clamp_limit(reg_wdata_in); // [RL18]
				OFS_HYST:
				begin
					// Negative words are treated as over range and clamp high.
					if (reg_wdata_in > HYST_MAX)
						cfg_q.hyst <= HYST_MAX; // [RL19]
					else
						cfg_q.hyst <= reg_wdata_in;
				end
				default:
				begin
				end
			endcase
		end
	end

	// ==========================================================
	// Source selection
	// ==========================================================
	logic [31:0] sel_value;

	always_comb
	begin
		sel_value = 32'h00000000;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (cfg_q.source == 5'(i))
				sel_value = src_in[i]; // [RL15]
		end
	end

	// ==========================================================
	// Filter
	// ==========================================================
	logic [31:0] filt_value;
	logic        filt_done;
	logic        filt_busy;

	sls_filter u_filter (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.start_in   (sample_tick_in), // [RL21]
		.sample_in  (sel_value),
		.time_in    (cfg_q.ftime),
		.value_out  (filt_value),
		.done_out   (filt_done),
		.busy_out   (filt_busy)
	);

	// ==========================================================
	// Comparison
	// ==========================================================
	logic [33:0] v_s;
	logic [33:0] v_m;
	logic [33:0] lo_s;
	logic [33:0] hi_s;
	logic [33:0] lo_m;
	logic [33:0] hi_m;
	logic [33:0] half_h;
	logic [33:0] band_top;
	logic [33:0] band_bot;
	logic        below_lo;
	logic        above_hi;
	logic        abs_below;
	logic        abs_above;
	logic        cond_q;
	logic        cond_d;

	assign v_s      = sx34(filt_value);
	assign v_m      = mag34(filt_value);
	assign lo_s     = sx34(cfg_q.low);
	assign hi_s     = sx34(cfg_q.high);
	assign lo_m     = mag34(cfg_q.low);
	assign hi_m     = mag34(cfg_q.high);
	assign half_h   = {3'h0, cfg_q.hyst[31:1]};
	assign band_top = hi_s + half_h; // [RL9]
	assign band_bot = hi_s - half_h; // [RL9]
	assign below_lo  = $signed(v_s) < $signed(lo_s);
	assign above_hi  = $signed(v_s) > $signed(hi_s);
	assign abs_below = v_m < lo_m;
	assign abs_above = v_m > hi_m;

	always_comb
	begin
		case (cfg_q.mode)
			MODE_OFF:
				cond_d = 1'b0; // [RL1]
			MODE_LOW:
				cond_d = below_lo; // [RL2]
			MODE_HIGH:
				cond_d = above_hi; // [RL3]
			MODE_ABS_LOW:
				cond_d = abs_below; // [RL4]
			MODE_ABS_HIGH:
				cond_d = abs_above; // [RL5]
			MODE_BOTH:
				cond_d = below_lo || above_hi; // [RL6]
			MODE_ABS_BOTH:
				cond_d = abs_below || abs_above; // [RL7]
			MODE_HYST:
			begin
				if ($signed(v_s) > $signed(band_top))
					cond_d = 1'b1; // [RL8]
				else if ($signed(v_s) < $signed(band_bot))
					cond_d = 1'b0; // [RL8]
				else
					cond_d = cond_q; // [RL9]
			end
			default:
				cond_d = 1'b0;
		endcase
	end

	// Switching the mode off drops the condition at once; other mode
	// changes take effect at the next finished sample.
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
			cond_q <= 1'b0;
		else if (cfg_q.mode == MODE_OFF)
			cond_q <= 1'b0; // [RL1]
		else if (filt_done)
			cond_q <= cond_d; // [RL21]
	end

	// ==========================================================
	// Events
	// ==========================================================
	logic        warn_q;
	logic        fault_q;
	logic [15:0] code_q;
	logic        rise;

	assign rise = filt_done && cfg_q.mode != MODE_OFF && cond_d && !cond_q;

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			warn_q  <= 1'b0;
			fault_q <= 1'b0;
			code_q  <= CODE_NONE;
		end
		else if (cfg_q.mode == MODE_OFF)
		begin
			warn_q  <= 1'b0; // [RL1]
			fault_q <= 1'b0;
			code_q  <= CODE_NONE;
		end
		else if (filt_done)
		begin
			warn_q  <= 1'b0;
			fault_q <= 1'b0;
			code_q  <= CODE_NONE;
			case (cfg_q.action)
				ACT_NONE:
				begin
				end // [RL10]
				ACT_WARN:
				begin
					warn_q <= cond_d; // [RL11]
					code_q <= cond_d ? CODE_WARN : CODE_NONE; // [RL11]
				end
				ACT_FAULT:
				begin
					fault_q <= rise; // [RL12]
					code_q  <= rise ? CODE_FAULT : CODE_NONE; // [RL12]
				end
				ACT_FAULT_RUN:
				begin
					fault_q <= rise && drive_running_in; // [RL13]
					code_q  <= (rise && drive_running_in) ? CODE_FAULT_RUN : CODE_NONE; // [RL13]
				end
				default:
				begin
				end
			endcase
		end
		else
		begin
			// A fault is a single-cycle trip request; a warning is a level.
			fault_q <= 1'b0;
			if (!warn_q)
				code_q <= CODE_NONE;
			if (cfg_q.action != ACT_WARN)
			begin
				warn_q <= 1'b0;
				code_q <= CODE_NONE;
			end
		end
	end

	assign event_out.cond  = cond_q; // [RL14]
	assign event_out.warn  = warn_q;
	assign event_out.fault = fault_q;
	assign event_out.code  = code_q;

	// ==========================================================
	// Read port
	// ==========================================================
	logic [31:0] rdata_q;
	logic [31:0] status_word;

	always_comb
	begin
		status_word           = 32'h00000000;
		status_word[POS_COND]  = cond_q; // [RL14]
		status_word[POS_WARN]  = warn_q;
		status_word[POS_FAULT] = fault_q;
		status_word[POS_BUSY]  = filt_busy;
	end

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
			rdata_q <= 32'h00000000;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				OFS_CTRL:
					rdata_q <= {19'h00000, cfg_q.source, 1'b0, 1'b0, cfg_q.action,
						1'b0, cfg_q.mode};
				OFS_FTIME:
					rdata_q <= {17'h00000, cfg_q.ftime};
				OFS_LOW:
					rdata_q <= cfg_q.low;
				OFS_HIGH:
					rdata_q <= cfg_q.high;
				OFS_HYST:
					rdata_q <= cfg_q.hyst;
				OFS_STATUS:
					rdata_q <= status_word;
				OFS_FILT:
					rdata_q <= filt_value;
				default:
					rdata_q <= 32'h00000000;
			endcase
		end
		else
			rdata_q <= 32'h00000000;
	end

	assign reg_rdata_out = rdata_q;

endmodule : sls_supervisor

// File: hdl/sls_pkg.sv
package sls_pkg;

	// ==========================================================
	// Register map, byte addresses of 32-bit words
	// ==========================================================
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_FTIME     = 8'h04;
	localparam logic [7:0]  OFS_LOW       = 8'h08;
	localparam logic [7:0]  OFS_HIGH      = 8'h0C;
	localparam logic [7:0]  OFS_HYST      = 8'h10;
	localparam logic [7:0]  OFS_STATUS    = 8'h14;
	localparam logic [7:0]  OFS_FILT      = 8'h18;

	// ==========================================================
	// Field positions inside the control word and the status word
	// ==========================================================
	localparam int          POS_MODE      = 0;
	localparam int          POS_ACTION    = 4;
	localparam int          POS_SOURCE    = 8;
	localparam int          POS_COND      = 0;
	localparam int          POS_WARN      = 1;
	localparam int          POS_FAULT     = 2;
	localparam int          POS_BUSY      = 3;

	// ==========================================================
	// Reset values and ranges, values in hundredths
	// ==========================================================
	localparam logic [2:0]  RST_MODE      = 3'h0;
	localparam logic [1:0]  RST_ACTION    = 2'h0;
	localparam logic [4:0]  RST_SOURCE    = 5'h04;
	localparam logic [14:0] RST_FTIME     = 15'h0000;
	localparam logic [31:0] RST_LIMIT     = 32'h00000000;
	localparam logic [31:0] RST_HYST      = 32'h00000000;
	localparam logic [14:0] FTIME_MAX_MS  = 15'h7530;
	localparam logic [31:0] LIMIT_MAX     = 32'h7FFFFFD0;
	localparam logic [31:0] LIMIT_MIN     = 32'h80000030;
	localparam logic [31:0] HYST_MAX      = 32'h00989680;
	localparam int          SAMPLE_MS     = 1;
	localparam int          DIV_STEPS     = 33;

	// ==========================================================
	// Event codes
	// ==========================================================
	localparam logic [15:0] CODE_NONE     = 16'h0000;
	localparam logic [15:0] CODE_WARN     = 16'hA8B1;
	localparam logic [15:0] CODE_FAULT    = 16'h80B1;
	localparam logic [15:0] CODE_FAULT_RUN = 16'h80B0;

	typedef enum logic [2:0] {
		MODE_OFF, MODE_LOW, MODE_HIGH, MODE_ABS_LOW,
		MODE_ABS_HIGH, MODE_BOTH, MODE_ABS_BOTH, MODE_HYST
	} sls_mode_e;

	typedef enum logic [1:0] {
		ACT_NONE, ACT_WARN, ACT_FAULT, ACT_FAULT_RUN
	} sls_action_e;

	typedef struct packed {
		sls_mode_e   mode;
		sls_action_e action;
		logic [4:0]  source;
		logic [14:0] ftime;
		logic [31:0] low;
		logic [31:0] high;
		logic [31:0] hyst;
	} sls_cfg_s;

	typedef struct packed {
		logic        cond;
		logic        warn;
		logic        fault;
		logic [15:0] code;
	} sls_event_s;

endpackage : sls_pkg

// File: hdl/sls_filter.sv
`timescale 1ns/1ns
module sls_filter
	import sls_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	// Sample side
	input  wire logic        start_in,
	input  wire logic [31:0] sample_in,
	input  wire logic [14:0] time_in,
	// Result side
	output logic      [31:0] value_out,
	output logic             done_out,
	output logic             busy_out
);
	import sls_pkg::*;

	// ==========================================================
	// First-order lag, y += (x - y) / (T / Ts + 1)
	// ==========================================================
	// A serial divider is used because ticks are far apart; one
	// division per tick costs a few dozen cycles and no multiplier.
	logic        busy_q;
	logic [5:0]  cnt_q;
	logic [32:0] num_q;
	logic [16:0] rem_q;
	logic [15:0] div_q;
	logic        neg_q;
	logic [31:0] y_q;
	logic        done_q;
	logic [32:0] diff;
	logic [16:0] trial;
	logic [32:0] ysum;

	assign diff  = {sample_in[31], sample_in} - {y_q[31], y_q};
	assign trial = {rem_q[15:0], num_q[32]};
	assign ysum  = neg_q ? ({y_q[31], y_q} - num_q) : ({y_q[31], y_q} + num_q);

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			busy_q <= 1'b0;
			cnt_q  <= 6'h00;
			num_q  <= 33'h000000000;
			rem_q  <= 17'h00000;
			div_q  <= 16'h0001;
			neg_q  <= 1'b0;
		end
		else if (!busy_q && start_in)
		begin
			busy_q <= 1'b1;
			cnt_q  <= 6'(DIV_STEPS);
			neg_q  <= diff[32];
			num_q  <= diff[32] ? (33'h000000000 - diff) : diff;
			rem_q  <= 17'h00000;
			div_q  <= {1'b0, time_in} / 16'(SAMPLE_MS) + 16'h0001; // [RL16]
		end
		else if (busy_q && cnt_q != 6'h00)
		begin
			cnt_q <= cnt_q - 6'h01;
			if (trial >= {1'b0, div_q})
			begin
				rem_q <= trial - {1'b0, div_q};
				num_q <= {num_q[31:0], 1'b1};
			end
			else
			begin
				rem_q <= trial;
				num_q <= {num_q[31:0], 1'b0};
			end
		end
		else if (busy_q)
		begin
			busy_q <= 1'b0;
		end
	end

	// The quotient never exceeds |x - y|, so the sum stays in range.
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			y_q    <= 32'h00000000;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= busy_q && cnt_q == 6'h00;
			if (busy_q && cnt_q == 6'h00)
				y_q <= ysum[31:0]; // [RL16]
		end
	end

	assign value_out = y_q;
	assign done_out  = done_q;
	assign busy_out  = busy_q;

endmodule : sls_filter

// File: tb/sls_checker.sv
`timescale 1ns/1ns
// ==========================================================
// Port checks of the supervision channel
// ==========================================================
module sls_checker
	import sls_pkg::*;
#(
	parameter int NUM_SRC = 28
)
(
	// Clock and reset
	input  wire logic                       clock_in,
	input  wire logic                       sys_rst_in,
	// Register port
	input  wire logic [sls_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]                reg_wdata_in,
	input  wire logic                       reg_wr_in,
	input  wire logic                       reg_rd_in,
	input  wire logic [31:0]                reg_rdata_out,
	// Monitored signals
	input  wire logic [NUM_SRC-1:0][31:0]   src_in,
	input  wire logic                       sample_tick_in,
	input  wire logic                       drive_running_in,
	// Events
	input  wire sls_pkg::sls_event_s        event_out
);
	import sls_pkg::*;

	logic [2:0] mode_q;
	logic [1:0] act_q;

	// Shadow of the control word, since the register itself is not visible here.
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			mode_q <= 3'h0;
			act_q  <= 2'h0;
		end
		else if (reg_wr_in && reg_addr_in == OFS_CTRL)
		begin
			mode_q <= reg_wdata_in[POS_MODE +: 3];
			act_q  <= reg_wdata_in[POS_ACTION +: 2];
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_rise_trip;
		$rose(event_out.cond) && act_q == ACT_FAULT;
	endsequence

	sequence s_one_pulse;
		event_out.fault ##1 !event_out.fault;
	endsequence

	a_off_quiet: assert property (
		mode_q == 3'h0 && $past(mode_q) == 3'h0 |-> !event_out.cond && !event_out.warn
		&& !event_out.fault) else $error("channel output active while off");
	a_trip_fault: assert property (s_rise_trip |-> s_one_pulse)
		else $error("no single fault pulse on rising condition");
	a_fault_rise: assert property (
		event_out.fault |-> event_out.cond && !$past(event_out.cond))
		else $error("fault without rising condition");
	a_trip_run: assert property (
		$rose(event_out.cond) && act_q == ACT_FAULT_RUN |-> event_out.fault ==
		$past(drive_running_in)) else $error("run-gated fault wrong");
	a_fault_code: assert property (
		event_out.fault |-> act_q[1] && event_out.code == (act_q[0] ? CODE_FAULT_RUN :
		CODE_FAULT)) else $error("fault code wrong");
	a_warn_code: assert property (
		event_out.warn |-> event_out.cond && event_out.code == CODE_WARN &&
		$past(act_q) == ACT_WARN) else $error("warning code or cause wrong");
	a_idle_code: assert property (
		!event_out.warn && !event_out.fault |-> event_out.code == CODE_NONE)
		else $error("code present without event");
	a_action_none: assert property (
		act_q == ACT_NONE && $past(act_q) == ACT_NONE |-> !event_out.warn && !event_out.fault)
		else $error("event raised with no action");
	a_eval_time: assert property (
		$changed(event_out.cond) && mode_q != 3'h0 |-> $past(sample_tick_in, 36))
		else $error("condition changed off the evaluation cycle");
endmodule : sls_checker

bind sls_supervisor sls_checker #(.NUM_SRC(NUM_SRC)) sls_checker_i (
	.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .src_in(src_in), .sample_tick_in(sample_tick_in),
	.drive_running_in(drive_running_in), .event_out(event_out));

// File: tb/sls_drive_model.sv
`timescale 1ns/1ns
// ==========================================================
// Drive side: takes the channel's events and trips the drive
// ==========================================================
module sls_drive_model
	import sls_pkg::*;
(
	// Clock and reset
	input  wire logic                clock_in,
	input  wire logic                sys_rst_in,
	// Bench control
	input  wire logic                run_cmd_in,
	input  wire logic                fault_ack_in,
	// Channel side
	input  wire sls_pkg::sls_event_s event_in,
	output logic                     running_out,
	output int                       trips_out
);
	import sls_pkg::*;

	logic tripped_q;

	// A trip stops the drive until acknowledged, as a real drive would.
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in || fault_ack_in)
			tripped_q <= 1'b0;
		else if (event_in.fault)
			tripped_q <= 1'b1;
	end

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
			trips_out <= 0;
		else if (event_in.fault)
			trips_out <= trips_out + 1;
	end

	assign running_out = run_cmd_in && !tripped_q;
endmodule : sls_drive_model

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
	import sls_pkg::*;
	localparam int NS = 28;
	logic                clock_in, sys_rst_in, reg_wr, reg_rd, tick, run_cmd, ack, running;
	logic [ADDR_W-1:0]   reg_addr;
	logic [31:0]         wdata, rdata;
	logic [NS-1:0][31:0] src;
	sls_event_s          ev;
	int                  trips, err_total, num_checks, exp_trips, mode, act, srcsel, ft;
	longint              y, lo, hi, hy;
	bit                  cond_m;
	longint              vals[14] = '{0, 801, 1001, 900, 1000, 599, 600, 700, -499, -501,
		500, 499, -1200, 1200};

	sls_supervisor #(.NUM_SRC(NS)) sls_supervisor_i (.clock_in(clock_in),
		.sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .src_in(src),
		.sample_tick_in(tick), .drive_running_in(running), .event_out(ev));
	sls_drive_model sls_drive_model_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.run_cmd_in(run_cmd), .fault_ack_in(ack), .event_in(ev), .running_out(running),
		.trips_out(trips));

	// ==========================================================
	// Checking and bus tasks
	// ==========================================================
	task automatic report_and_stop;
		if (err_total == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk_word

	task automatic chk_ev(input sls_event_s e, input sls_event_s g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected event: expected %h, seen %h", e, g);
		end
	endtask : chk_ev

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_wr <= 1'b1;
		reg_addr <= a;
		wdata <= d;
		@(posedge clock_in);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m,
		input string n);
		@(posedge clock_in);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock_in);
		reg_rd <= 1'b0;
		@(negedge clock_in);
		chk_word(n, e & m, rdata & m);
	endtask : rd

	function automatic bit cmp(longint v, bit prev);
		longint av = v < 0 ? -v : v;
		longint al = lo < 0 ? -lo : lo;
		longint ah = hi < 0 ? -hi : hi;
		case (mode)
			1: return v < lo;
			2: return v > hi;
			3: return av < al;
			4: return av > ah;
			5: return v < lo || v > hi;
			6: return av < al || av > ah;
			7: return v > hi + hy / 2 ? 1'b1 : v < hi - hy / 2 ? 1'b0 : prev;
			default: return 1'b0;
		endcase
	endfunction : cmp

	// One tick, then the model result is compared at the fixed evaluation cycle.
	task automatic sample(input longint x, input bit run);
		sls_event_s e;
		@(posedge clock_in);
		for (int i = 0; i < NS; i++)
			src[i] <= (i == srcsel) ? 32'(x) : $urandom;
		run_cmd <= run;
		ack <= 1'b1;
		tick <= 1'b1;
		@(posedge clock_in);
		tick <= 1'b0;
		ack <= 1'b0;
		rd(OFS_STATUS, 32'h1 << POS_BUSY, 32'h1 << POS_BUSY, "busy flag");
		repeat (33) @(posedge clock_in);
		@(negedge clock_in);
		y = ft == 0 ? x : y + (x - y) / (ft + 1);
		e.cond = mode != 0 && cmp(y, cond_m);
		e.warn = e.cond && act == 1;
		e.fault = e.cond && !cond_m && (act == 2 || (act == 3 && run));
		e.code = e.fault ? (act == 3 ? CODE_FAULT_RUN : CODE_FAULT) : e.warn ? CODE_WARN
			: CODE_NONE;
		cond_m = e.cond;
		exp_trips += e.fault;
		chk_ev(e, ev);
		rd(OFS_STATUS, 32'(e.warn) << POS_WARN | 32'(e.cond), 32'hFFFFFFFF, "status");
		rd(OFS_FILT, 32'(y), 32'hFFFFFFFF, "filtered value");
	endtask : sample

	// ==========================================================
	// Clock, watchdog and main sequence
	// ==========================================================
	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	initial
	begin
		#600000;
		err_total++;
		report_and_stop();
	end

	initial
	begin
		logic [ADDR_W-1:0] ra[8] = '{OFS_CTRL, OFS_FTIME, OFS_LOW, OFS_HIGH, OFS_HYST,
			OFS_STATUS, OFS_FILT, 8'h1C};
		logic [ADDR_W-1:0] ca[4] = '{OFS_FTIME, OFS_LOW, OFS_HIGH, OFS_HYST};
		logic [31:0] cw[4] = '{32'h00007FFF, 32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF};
		logic [31:0] ce[4] = '{32'(FTIME_MAX_MS), LIMIT_MAX, LIMIT_MIN, HYST_MAX};
		{sys_rst_in, reg_wr, reg_rd, tick, run_cmd, ack} = 6'h20;
		{reg_addr, wdata, src} = '0;
		{err_total, num_checks, exp_trips, mode, act, srcsel, ft} = '0;
		{y, lo, hi, hy, cond_m} = '0;
		void'($urandom(32'hEDB1));
		repeat (5) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		foreach (ra[i])
			rd(ra[i], i == 0 ? 32'(RST_SOURCE) << POS_SOURCE : 32'h0, 32'hFFFFFFFF,
				"reset word");
		foreach (ca[i])
		begin
			wr(ca[i], cw[i]);
			rd(ca[i], ce[i], 32'hFFFFFFFF, "clamped word");
		end
		{lo, hi, hy} = {-64'sd500, 64'sd800, 64'sd400};
		wr(OFS_FTIME, 32'h0);
		wr(OFS_LOW, 32'(lo));
		wr(OFS_HIGH, 32'(hi));
		wr(OFS_HYST, 32'(hy));
		for (int m = 1; m < 8; m++)
			for (int a = 0; a < 4; a++)
			begin
				{mode, act, srcsel} = {m, a, int'($urandom_range(0, NS - 1))};
				wr(OFS_CTRL, 32'(m) | 32'(a) << POS_ACTION | 32'(srcsel) << POS_SOURCE);
				foreach (vals[k])
					sample(vals[k], 1'($urandom_range(0, 1)));
				sample(longint'($urandom_range(0, 4000)) - 2000, 1'b1);
			end
		// A slow filter keeps part of the old state, so a step reaches the limit late.
		ft = 2;
		wr(OFS_FTIME, 32'(ft));
		repeat (4) sample(3000, 1'b1);
		// Keep the source so the filter keeps following the driven input.
		wr(OFS_CTRL, 32'(srcsel) << POS_SOURCE);
		@(posedge clock_in);
		@(negedge clock_in);
		chk_ev('0, ev);
		{mode, cond_m} = '0;
		sample(5000, 1'b1);
		chk_word("trip count", exp_trips, trips);
		report_and_stop();
	end
endmodule : tb
